// ---- common/rx_status_consts.svh ----
// offsets, flag positions and reset values of the receiver status bank
// assumes: included by bare name; 7-bit control port register addresses
`ifndef RX_STATUS_CONSTS_SVH
`define RX_STATUS_CONSTS_SVH
`define OFS_SAMPLE_RATIO_LOW 7'h13
`define OFS_BURST_PC_HIGH 7'h14
`define OFS_BURST_PC_LOW 7'h15
`define OFS_BURST_PD_HIGH 7'h16
`define OFS_BURST_PD_LOW 7'h17
`define OFS_RX_ERROR_FLAGS 7'h18
`define OFS_RX_ERROR_IRQ_ENABLE 7'h19
`define POS_VALID 7
`define POS_EMPHASIS 6
`define POS_NONPCM 5
`define POS_PREAMBLE 4
`define POS_CS_CHECK 3
`define POS_NO_INPUT 2
`define POS_BIPHASE 1
`define POS_LOCK 0
`define STICKY_MASK 8'h0a
`define RST_IRQ_ENABLE 8'h00
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`endif

// ---- common/rx_status_pkg.sv ----
// types shared by the receiver status bank
// assumes: compiled before the design modules
package rx_status_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [6:0] reg_addr_t;
   typedef enum logic {
      FLAG_LEVEL = 1'b0,
      FLAG_STICKY = 1'b1
   } flag_kind_e;
endpackage : rx_status_pkg

// ---- design/rx_flag_cell.sv ----
// one receiver error flag with its pending-interrupt bit
// assumes: event_in is a one-cycle pulse, rd_clr a read strobe
`timescale 1ns/10ps
`default_nettype none
module rx_flag_cell
   import rx_status_pkg::*;
#(
   parameter flag_kind_e KIND = FLAG_LEVEL
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic level_in,
   input wire logic event_in,
   input wire logic rd_clr,
   output logic flag_q,
   output logic pend_q
);
   logic flag_d;
   logic pend_d;
   logic changed;
   logic set_pend;

   // level flags interrupt on change or on their event, sticky ones on the event
   assign changed = level_in != flag_q;
   assign set_pend = (KIND == FLAG_STICKY) ? event_in : (changed | event_in);
   // set wins over the read clear
   assign flag_d = (KIND == FLAG_STICKY) ? (event_in | (flag_q & ~rd_clr)) : level_in;
   assign pend_d = set_pend | (pend_q & ~rd_clr);

   // flag and pending state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         pend_q <= pend_d;
      end
   end
endmodule : rx_flag_cell
`default_nettype wire

// ---- design/rx_burst_capture.sv ----
// holds the burst preamble words while non-pcm data is detected
// assumes: cap_stb is a one-cycle pulse with the words valid
`timescale 1ns/10ps
`default_nettype none
`include "rx_status_consts.svh"
module rx_burst_capture
   import rx_status_pkg::*;
#(
   parameter int WORD_W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic detect,
   input wire logic cap_stb,
   input wire logic subframe_mode,
   input wire logic [WORD_W-1:0] pc_word,
   input wire logic [WORD_W-1:0] pd_word,
   input wire logic [WORD_W-1:0] pc_chb_word,
   output logic [WORD_W-1:0] pc_q,
   output logic [WORD_W-1:0] pd_q
);
   logic [WORD_W-1:0] pd_src;

   // subframe mode loads the channel b preamble c word
   assign pd_src = subframe_mode ? pc_chb_word : pd_word;

   // words fall to zero whenever detection is gone
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_q <= '0;
         pd_q <= '0;
      end else if (!detect) begin
         pc_q <= '0;
         pd_q <= '0;
      end else if (cap_stb) begin
         pc_q <= pc_word;
         pd_q <= pd_src;
      end
   end
endmodule : rx_burst_capture
`default_nettype wire

// ---- design/receiver_status_flags.sv ----
// receiver status bank: ratio byte, burst preambles, error flags, mask
// assumes: one register access per cycle from the control port logic
`timescale 1ns/10ps
`default_nettype none
`include "rx_status_consts.svh"
module receiver_status_flags
   import rx_status_pkg::*;
#(
   parameter int RATIO_W = 15,
   parameter int WORD_W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [6:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   output logic reg_rvalid_q,
   input wire logic [RATIO_W-1:0] sample_ratio_value,
   input wire logic burst_detect,
   input wire logic burst_stb,
   input wire logic subframe_mode,
   input wire logic [WORD_W-1:0] pc_word,
   input wire logic [WORD_W-1:0] pd_word,
   input wire logic [WORD_W-1:0] pc_chb_word,
   input wire logic rx_validity,
   input wire logic emphasis_in,
   input wire logic nonpcm_cs_bit,
   input wire logic nonpcm_type_chg,
   input wire logic cs_crc_fail,
   input wire logic stream_absent,
   input wire logic biphase_err,
   input wire logic parity_err,
   input wire logic pll_locked,
   output logic rx_error_irq_q
);
   localparam reg_byte_t STICKY = `STICKY_MASK;

   // address compare shared by every decode
   function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
      hit = (a == ofs);
   endfunction : hit

   logic [RATIO_W-1:0] ratio_q;
   reg_byte_t mask_q;
   reg_byte_t mask_d;
   reg_byte_t rdata_d;
   logic irq_d;
   logic [WORD_W-1:0] pc_q;
   logic [WORD_W-1:0] pd_q;
   logic [WORD_W-1:0] pc_show;
   logic [WORD_W-1:0] pd_show;
   reg_byte_t flag_lvl;
   reg_byte_t flag_evt;
   reg_byte_t flag_clr;
   reg_byte_t err_flags;
   reg_byte_t err_pend;
   logic err_rd;
   logic mask_wr;

   // ratio value sampled every cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ratio_q <= '0;
      end else begin
         ratio_q <= sample_ratio_value;
      end
   end

   // preamble capture
   rx_burst_capture #(
      .WORD_W(WORD_W)
   ) u_burst (
      .clk(clk),
      .sys_rst(sys_rst),
      .detect(burst_detect),
      .cap_stb(burst_stb),
      .subframe_mode(subframe_mode),
      .pc_word(pc_word),
      .pd_word(pd_word),
      .pc_chb_word(pc_chb_word),
      .pc_q(pc_q),
      .pd_q(pd_q)
   );

   // preamble bytes read zero without detection
   assign pc_show = burst_detect ? pc_q : `RST_WORD;
   assign pd_show = burst_detect ? pd_q : `RST_WORD;

   // flag sources: levels for change flags, pulses for sticky ones and for the non-pcm type change
   assign flag_lvl[`POS_VALID] = rx_validity;
   assign flag_lvl[`POS_EMPHASIS] = emphasis_in;
   assign flag_lvl[`POS_NONPCM] = nonpcm_cs_bit;
   assign flag_lvl[`POS_PREAMBLE] = burst_detect;
   assign flag_lvl[`POS_CS_CHECK] = 1'b0;
   assign flag_lvl[`POS_NO_INPUT] = stream_absent;
   assign flag_lvl[`POS_BIPHASE] = 1'b0;
   assign flag_lvl[`POS_LOCK] = pll_locked;

   assign flag_evt[`POS_VALID] = 1'b0;
   assign flag_evt[`POS_EMPHASIS] = 1'b0;
   assign flag_evt[`POS_NONPCM] = nonpcm_type_chg;
   assign flag_evt[`POS_PREAMBLE] = 1'b0;
   assign flag_evt[`POS_CS_CHECK] = cs_crc_fail;
   assign flag_evt[`POS_NO_INPUT] = 1'b0;
   assign flag_evt[`POS_BIPHASE] = biphase_err | parity_err;
   assign flag_evt[`POS_LOCK] = 1'b0;

   // access decode
   assign err_rd = reg_rd & hit(reg_addr, `OFS_RX_ERROR_FLAGS);
   assign mask_wr = reg_wr & hit(reg_addr, `OFS_RX_ERROR_IRQ_ENABLE);

   // a read clears the pending bits of all level flags and the sticky flags it returned; sticky zeros stay untouched
   assign flag_clr = err_rd ? (~STICKY | err_flags) : `RST_BYTE;

   // one cell per flag position
   for (genvar i = 0; i < 8; i++) begin : g_flag
      rx_flag_cell #(
         .KIND(STICKY[i] ? FLAG_STICKY : FLAG_LEVEL)
      ) u_cell (
         .clk(clk),
         .sys_rst(sys_rst),
         .level_in(flag_lvl[i]),
         .event_in(flag_evt[i]),
         .rd_clr(flag_clr[i]),
         .flag_q(err_flags[i]),
         .pend_q(err_pend[i])
      );
   end

   // mask register write
   assign mask_d = mask_wr ? reg_wdata : mask_q;

   // read data mux; unmapped addresses read zero
   assign rdata_d =
      hit(reg_addr, `OFS_SAMPLE_RATIO_LOW) ? ratio_q[7:0] :
      hit(reg_addr, `OFS_BURST_PC_HIGH) ? pc_show[15:8] :
      hit(reg_addr, `OFS_BURST_PC_LOW) ? pc_show[7:0] :
      hit(reg_addr, `OFS_BURST_PD_HIGH) ? pd_show[15:8] :
      hit(reg_addr, `OFS_BURST_PD_LOW) ? pd_show[7:0] :
      hit(reg_addr, `OFS_RX_ERROR_FLAGS) ? err_flags :
      hit(reg_addr, `OFS_RX_ERROR_IRQ_ENABLE) ? mask_q :
      `RST_BYTE;

   // pending flags pass only where the mask bit is one
   assign irq_d = |(err_pend & mask_q);

   // register state and outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_q <= `RST_IRQ_ENABLE;
         reg_rdata_q <= `RST_BYTE;
         reg_rvalid_q <= 1'b0;
         rx_error_irq_q <= 1'b0;
      end else begin
         mask_q <= mask_d;
         reg_rdata_q <= reg_rd ? rdata_d : reg_rdata_q;
         reg_rvalid_q <= reg_rd;
         rx_error_irq_q <= irq_d;
      end
   end

   // checks on the bank
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ratio low byte answers one cycle after the read
   property p_ratio_low;
      reg_rd && hit(reg_addr, `OFS_SAMPLE_RATIO_LOW)
      |=> reg_rvalid_q && reg_rdata_q == $past(sample_ratio_value[7:0], 2);
   endproperty
   a_ratio_low: assert property (p_ratio_low) else $error("ratio byte wrong");

   // preamble c reads zero without detection
   property p_pc_zero;
      reg_rd && !burst_detect && hit(reg_addr, `OFS_BURST_PC_HIGH)
      |=> reg_rdata_q == `RST_BYTE;
   endproperty
   a_pc_zero: assert property (p_pc_zero) else $error("pc not zero");

   // preamble d reads zero without detection
   property p_pd_zero;
      reg_rd && !burst_detect && hit(reg_addr, `OFS_BURST_PD_LOW)
      |=> reg_rdata_q == `RST_BYTE;
   endproperty
   a_pd_zero: assert property (p_pd_zero) else $error("pd not zero");

   // subframe mode: pd high byte is channel b preamble c
   property p_pd_sub;
      (burst_detect && burst_stb && subframe_mode) ##1
      (burst_detect && !burst_stb && reg_rd && hit(reg_addr, `OFS_BURST_PD_HIGH))
      |=> reg_rdata_q == $past(pc_chb_word[15:8], 2);
   endproperty
   a_pd_sub: assert property (p_pd_sub) else $error("pd not chb word");

   // validity bit read back with two cycles of latency
   property p_valid_bit;
      err_rd |=> reg_rdata_q[`POS_VALID] == $past(rx_validity, 2);
   endproperty
   a_valid_bit: assert property (p_valid_bit) else $error("validity bit wrong");

   // emphasis: a read with no change leaves nothing pending
   property p_emph_quiet;
      err_rd && emphasis_in == err_flags[`POS_EMPHASIS]
      |=> !err_pend[`POS_EMPHASIS] && err_flags[`POS_EMPHASIS] == $past(emphasis_in);
   endproperty
   a_emph_quiet: assert property (p_emph_quiet) else $error("emphasis pending");

   // non-pcm type change raises pending
   property p_nonpcm_type;
      nonpcm_type_chg |=> err_pend[`POS_NONPCM];
   endproperty
   a_nonpcm_type: assert property (p_nonpcm_type) else $error("type change lost");

   // preamble detect change raises pending
   property p_preamble_chg;
      burst_detect != err_flags[`POS_PREAMBLE] |=> err_pend[`POS_PREAMBLE];
   endproperty
   a_preamble_chg: assert property (p_preamble_chg) else $error("preamble chg lost");

   // crc flag holds until a read
   property p_crc_hold;
      err_flags[`POS_CS_CHECK] && !err_rd |=> err_flags[`POS_CS_CHECK];
   endproperty
   a_crc_hold: assert property (p_crc_hold) else $error("crc flag dropped");

   // no-input change raises pending
   property p_noin_chg;
      stream_absent != err_flags[`POS_NO_INPUT] |=> err_pend[`POS_NO_INPUT];
   endproperty
   a_noin_chg: assert property (p_noin_chg) else $error("no-input chg lost");

   // biphase or parity error sets the flag and a read clears it
   property p_biphase;
      (biphase_err || parity_err) ##1 (err_rd && !biphase_err && !parity_err)
      |=> !err_flags[`POS_BIPHASE];
   endproperty
   a_biphase: assert property (p_biphase) else $error("biphase flag wrong");

   // lock flag follows the pll one cycle later
   property p_lock;
      pll_locked |=> err_flags[`POS_LOCK] ##1 err_flags[`POS_LOCK] == $past(pll_locked);
   endproperty
   a_lock: assert property (p_lock) else $error("lock flag wrong");

   // mask write reads back on the next read
   property p_mask_rb;
      mask_wr ##1 (reg_rd && !reg_wr && hit(reg_addr, `OFS_RX_ERROR_IRQ_ENABLE))
      |=> reg_rdata_q == $past(reg_wdata, 2);
   endproperty
   a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");

   // a cleared mask keeps the interrupt low
   property p_mask_block;
      (mask_q == `RST_BYTE) [*2] |-> !rx_error_irq_q;
   endproperty
   a_mask_block: assert property (p_mask_block) else $error("masked irq seen");

   // an enabled pending lock flag raises the interrupt next cycle
   property p_mask_pass;
      (err_pend[`POS_LOCK] && mask_q[`POS_LOCK]) |=> rx_error_irq_q;
   endproperty
   a_mask_pass: assert property (p_mask_pass) else $error("irq missing");

   // a crc event during the clearing read survives it
   property p_crc_kept;
      cs_crc_fail && err_rd |=> err_flags[`POS_CS_CHECK] && err_pend[`POS_CS_CHECK];
   endproperty
   a_crc_kept: assert property (p_crc_kept) else $error("crc event lost");

   // validity change raises pending
   property p_valid_chg;
      rx_validity != err_flags[`POS_VALID] |=> err_pend[`POS_VALID];
   endproperty
   a_valid_chg: assert property (p_valid_chg) else $error("validity chg lost");

   // emphasis change raises pending, also during a read
   property p_emph_chg;
      emphasis_in != err_flags[`POS_EMPHASIS] |=> err_pend[`POS_EMPHASIS];
   endproperty
   a_emph_chg: assert property (p_emph_chg) else $error("emphasis chg lost");

   // crc failure sets the flag and its pending bit
   property p_crc_set;
      cs_crc_fail |=> err_flags[`POS_CS_CHECK] && err_pend[`POS_CS_CHECK];
   endproperty
   a_crc_set: assert property (p_crc_set) else $error("crc not set");

   // a read with no new crc event empties the flag
   property p_crc_clr;
      err_rd && !cs_crc_fail |=> !err_flags[`POS_CS_CHECK];
   endproperty
   a_crc_clr: assert property (p_crc_clr) else $error("crc not cleared");

   // biphase or parity error sets the shared flag
   property p_biphase_set;
      (biphase_err || parity_err) |=> err_flags[`POS_BIPHASE] && err_pend[`POS_BIPHASE];
   endproperty
   a_biphase_set: assert property (p_biphase_set) else $error("biphase not set");

   // lock change raises pending
   property p_lock_chg;
      pll_locked != err_flags[`POS_LOCK] |=> err_pend[`POS_LOCK];
   endproperty
   a_lock_chg: assert property (p_lock_chg) else $error("lock chg lost");

   // main scenarios
   property p_cov_crc_read;
      err_rd && err_flags[`POS_CS_CHECK];
   endproperty
   c_crc_read: cover property (p_cov_crc_read);

   property p_cov_irq;
      !rx_error_irq_q ##1 rx_error_irq_q;
   endproperty
   c_irq: cover property (p_cov_irq);

   property p_cov_sub;
      burst_detect && burst_stb && subframe_mode;
   endproperty
   c_sub: cover property (p_cov_sub);

   property p_cov_mask;
      mask_wr && reg_wdata != `RST_BYTE;
   endproperty
   c_mask: cover property (p_cov_mask);
endmodule : receiver_status_flags
`default_nettype wire

// ---- bench/test_receiver_status_flags.sv ----
// self-checking bench for the receiver status bank: ratio, preambles, flags, mask
// assumes: design and package compiled first; strobe register port; one 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "rx_status_consts.svh"
module test_receiver_status_flags
   import rx_status_pkg::*;
;
   logic clk, sys_rst, reg_rd, reg_wr, reg_rvalid_q, rx_error_irq_q;
   reg_addr_t reg_addr;
   reg_byte_t reg_wdata, reg_rdata_q, rd_val;
   logic [14:0] sample_ratio_value;
   logic [15:0] pc_word, pd_word, pc_chb_word;
   logic burst_detect, burst_stb, subframe_mode, rx_validity, emphasis_in, nonpcm_cs_bit;
   logic nonpcm_type_chg, cs_crc_fail, stream_absent, biphase_err, parity_err, pll_locked;
   int n_mismatch, n_checks;

   receiver_status_flags #(.RATIO_W(15), .WORD_W(16)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
      .sample_ratio_value(sample_ratio_value), .burst_detect(burst_detect),
      .burst_stb(burst_stb), .subframe_mode(subframe_mode), .pc_word(pc_word),
      .pd_word(pd_word), .pc_chb_word(pc_chb_word), .rx_validity(rx_validity),
      .emphasis_in(emphasis_in), .nonpcm_cs_bit(nonpcm_cs_bit),
      .nonpcm_type_chg(nonpcm_type_chg), .cs_crc_fail(cs_crc_fail),
      .stream_absent(stream_absent), .biphase_err(biphase_err), .parity_err(parity_err),
      .pll_locked(pll_locked), .rx_error_irq_q(rx_error_irq_q));

   // free-running clock, 10 ns period
   always #5 clk = ~clk;

   task automatic end_of_test();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic waitn(input int n);
      repeat (n) @(negedge clk);
   endtask : waitn

   // one read strobe; ev raises the crc event in the same cycle
   task automatic rd(input reg_addr_t a, input logic ev, output reg_byte_t d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      cs_crc_fail = ev;
      @(negedge clk);
      reg_rd = 1'b0;
      cs_crc_fail = 1'b0;
      chk({7'h00, reg_rvalid_q}, 8'h01);
      d = reg_rdata_q;
   endtask : rd

   task automatic rdc(input reg_addr_t a, input reg_byte_t exp);
      reg_byte_t d;
      rd(a, 1'b0, d);
      chk(d, exp);
   endtask : rdc

   task automatic wr(input reg_addr_t a, input reg_byte_t d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic irq_is(input logic v);
      chk({7'h00, rx_error_irq_q}, {7'h00, v});
   endtask : irq_is

   // drive the status source behind flag bit i
   task automatic drive(input int i, input logic v);
      @(negedge clk);
      case (i)
         7: rx_validity = v;
         6: emphasis_in = v;
         5: nonpcm_cs_bit = v;
         4: burst_detect = v;
         3: cs_crc_fail = v;
         2: stream_absent = v;
         1: biphase_err = v;
         default: pll_locked = v;
      endcase
   endtask : drive

   // watchdog cuts a hang short
   initial begin
      #200us;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      clk = 1'b0; sys_rst = 1'b1; reg_addr = 7'h00; reg_rd = 1'b0; reg_wr = 1'b0;
      reg_wdata = 8'h00; sample_ratio_value = 15'h0000; burst_detect = 1'b0;
      burst_stb = 1'b0; subframe_mode = 1'b0; pc_word = 16'h0000; pd_word = 16'h0000;
      pc_chb_word = 16'h0000; rx_validity = 1'b0; emphasis_in = 1'b0;
      nonpcm_cs_bit = 1'b0; nonpcm_type_chg = 1'b0; cs_crc_fail = 1'b0;
      stream_absent = 1'b0; biphase_err = 1'b0; parity_err = 1'b0; pll_locked = 1'b0;
      n_mismatch = 0; n_checks = 0;
      waitn(12);
      sys_rst = 1'b0;
      // reset values, unmapped read and ignored writes
      rdc(`OFS_RX_ERROR_IRQ_ENABLE, `RST_IRQ_ENABLE);
      rdc(`OFS_RX_ERROR_FLAGS, 8'h00);
      rdc(7'h1a, 8'h00);
      sample_ratio_value = 15'h5a3c;
      wr(`OFS_SAMPLE_RATIO_LOW, 8'hff);
      rdc(`OFS_SAMPLE_RATIO_LOW, 8'h3c);
      wr(`OFS_RX_ERROR_IRQ_ENABLE, 8'ha5);
      rdc(`OFS_RX_ERROR_IRQ_ENABLE, 8'ha5);
      // write then read in back-to-back cycles
      @(negedge clk);
      reg_addr = `OFS_RX_ERROR_IRQ_ENABLE;
      reg_wdata = 8'h5a;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(reg_rdata_q, 8'h5a);
      wr(`OFS_RX_ERROR_FLAGS, 8'hff);
      rdc(`OFS_RX_ERROR_FLAGS, 8'h00);
      // preamble capture, then channel b word, then zeros when undetected
      rdc(`OFS_BURST_PC_HIGH, 8'h00);
      @(negedge clk);
      burst_detect = 1'b1; pc_word = 16'h1234; pd_word = 16'h5678; pc_chb_word = 16'h9abc;
      burst_stb = 1'b1;
      @(negedge clk);
      burst_stb = 1'b0;
      rdc(`OFS_BURST_PC_HIGH, 8'h12);
      rdc(`OFS_BURST_PC_LOW, 8'h34);
      rdc(`OFS_BURST_PD_HIGH, 8'h56);
      rdc(`OFS_BURST_PD_LOW, 8'h78);
      @(negedge clk);
      subframe_mode = 1'b1;
      burst_stb = 1'b1;
      @(negedge clk);
      burst_stb = 1'b0;
      reg_addr = `OFS_BURST_PD_HIGH;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(reg_rdata_q, 8'h9a);
      rdc(`OFS_BURST_PD_HIGH, 8'h9a);
      rdc(`OFS_BURST_PD_LOW, 8'hbc);
      rdc(`OFS_BURST_PC_HIGH, 8'h12);
      @(negedge clk);
      burst_detect = 1'b0;
      subframe_mode = 1'b0;
      rdc(`OFS_BURST_PC_LOW, 8'h00);
      rdc(`OFS_BURST_PD_LOW, 8'h00);
      // every error flag with its own mask bit; level flags then also masked off
      for (int i = 0; i < 8; i++) begin
         wr(`OFS_RX_ERROR_IRQ_ENABLE, 8'h00);
         rd(`OFS_RX_ERROR_FLAGS, 1'b0, rd_val);
         wr(`OFS_RX_ERROR_IRQ_ENABLE, 8'h01 << i);
         if (`STICKY_MASK & (8'h01 << i)) begin
            drive(i, 1'b1);
            drive(i, 1'b0);
            waitn(3);
            irq_is(1'b1);
            rdc(`OFS_RX_ERROR_FLAGS, 8'h01 << i);
            waitn(1);
            irq_is(1'b0);
            rdc(`OFS_RX_ERROR_FLAGS, 8'h00);
         end else begin
            drive(i, 1'b1);
            waitn(3);
            irq_is(1'b1);
            rdc(`OFS_RX_ERROR_FLAGS, 8'h01 << i);
            waitn(1);
            irq_is(1'b0);
            waitn(3);
            irq_is(1'b0);
            rdc(`OFS_RX_ERROR_FLAGS, 8'h01 << i);
            drive(i, 1'b0);
            waitn(3);
            irq_is(1'b1);
            rdc(`OFS_RX_ERROR_FLAGS, 8'h00);
            wr(`OFS_RX_ERROR_IRQ_ENABLE, 8'h00);
            drive(i, 1'b1);
            waitn(3);
            irq_is(1'b0);
            drive(i, 1'b0);
         end
      end
      // parity error shares the biphase bit
      wr(`OFS_RX_ERROR_IRQ_ENABLE, 8'h02);
      rd(`OFS_RX_ERROR_FLAGS, 1'b0, rd_val);
      @(negedge clk);
      parity_err = 1'b1;
      @(negedge clk);
      parity_err = 1'b0;
      reg_addr = `OFS_RX_ERROR_FLAGS;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(reg_rdata_q, 8'h02);
      irq_is(1'b1);
      waitn(1);
      irq_is(1'b0);
      rdc(`OFS_RX_ERROR_FLAGS, 8'h00);
      // type change of non-pcm data interrupts again after a read
      wr(`OFS_RX_ERROR_IRQ_ENABLE, 8'h20);
      drive(5, 1'b1);
      waitn(2);
      rdc(`OFS_RX_ERROR_FLAGS, 8'h20);
      waitn(2);
      irq_is(1'b0);
      @(negedge clk);
      nonpcm_type_chg = 1'b1;
      @(negedge clk);
      nonpcm_type_chg = 1'b0;
      waitn(2);
      irq_is(1'b1);
      rdc(`OFS_RX_ERROR_FLAGS, 8'h20);
      drive(5, 1'b0);
      // crc event landing on the clearing read stays pending
      wr(`OFS_RX_ERROR_IRQ_ENABLE, 8'h08);
      rd(`OFS_RX_ERROR_FLAGS, 1'b0, rd_val);
      drive(3, 1'b1);
      drive(3, 1'b0);
      waitn(2);
      rd(`OFS_RX_ERROR_FLAGS, 1'b1, rd_val);
      chk(rd_val, 8'h08);
      waitn(2);
      irq_is(1'b1);
      rdc(`OFS_RX_ERROR_FLAGS, 8'h08);
      rdc(`OFS_RX_ERROR_FLAGS, 8'h00);
      end_of_test();
   end
endmodule : test_receiver_status_flags
`default_nettype wire
